// [rtl/csb_pkg.sv]
// Constants and types for the compact status byte encoder
package csb_pkg;
	// Time base
	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam int unsigned SECOND_NS = 1000000000;
	localparam int unsigned TICK_CYCLES = SECOND_NS / CLK_PERIOD_NS;
	// Measurement timing, in one-second ticks
	localparam logic [7:0] STALE_LIMIT_S = 8'h0A;
	localparam logic [7:0] AVG_SPLIT_S = 8'h0A;
	localparam logic [7:0] STATIC_LIMIT_S = 8'h3C;
	localparam logic [7:0] SAT_S = 8'hFF;
	// Register map (byte addresses)
	localparam logic [7:0] OFS_AVG_TIME = 8'h00;
	localparam logic [7:0] OFS_COMPACT = 8'h04;
	localparam logic [7:0] OFS_EXTENDED = 8'h08;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
	localparam logic [7:0] AVG_TIME_RESET = 8'h0A;
	// Compact status byte fields
	localparam int CB_GEN = 0;
	localparam int CB_FILL_LO = 1;
	localparam int CB_RSV = 4;
	localparam int CB_STATIC = 5;
	localparam int CB_HCRIT = 6;
	localparam int CB_HON = 7;
	// Extended status word fields
	localparam int EX_GEN = 0;
	localparam int EX_HCRIT = 1;
	localparam int EX_HON = 2;
	localparam int EX_STATIC = 4;
	localparam int EX_FILL_LO = 8;
	localparam int EX_FILL_HI = 11;
	localparam int EX_RESTART = 13;
	// Interrupt status and mask fields
	localparam int IRQ_W = 3;
	localparam int IRQ_GEN = 0;
	localparam int IRQ_STATIC = 1;
	localparam int IRQ_HEAT = 2;
	localparam int FILL16_STEPS = 15;

	typedef struct packed {
		logic new_value;
		logic acoustic_virtual_temperature_fault;
		logic heat_criterion;
		logic heat_on;
		logic [7:0] buf_count;
	} csb_meas_type;
endpackage : csb_pkg

// [rtl/csb_tick_div.sv]
// One-cycle enable pulse every DIV clock cycles
`timescale 1ns/1ps
module csb_tick_div #(
	parameter int unsigned DIV = 10
) (
	input wire logic hclk,
	input wire logic hresetn,
	output logic tick_o
);
	logic [31:0] cnt_r;
	logic wrap;

	assign wrap = (cnt_r == 32'(DIV - 1));

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cnt_r <= 32'h0;
			tick_o <= 1'b0;
		end
		else
		begin
			cnt_r <= wrap ? 32'h0 : cnt_r + 32'h1;
			tick_o <= wrap;
		end
	end
endmodule : csb_tick_div

// [rtl/csb_status_top.sv]
// Compact status byte encoder with AHB-Lite register slave
//
// The implementer's own choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
module csb_status_top
	import csb_pkg::*;
#(
	parameter int unsigned TICK_DIV = csb_pkg::TICK_CYCLES
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire csb_pkg::csb_meas_type meas_i,
	output logic [7:0] compact_status_o,
	output logic irq_o
);
	import csb_pkg::*;

	csb_meas_type meas_r;
	logic tick;
	logic [7:0] avg_r;
	logic [7:0] stale_r;
	logic [7:0] static_sec_r;
	logic [31:0] ext_r;
	logic [31:0] ext_nxt;
	logic restart_r;
	logic [IRQ_W-1:0] irq_stat_r;
	logic [IRQ_W-1:0] irq_stat_nxt;
	logic [IRQ_W-1:0] irq_mask_r;
	logic [IRQ_W-1:0] evt;
	logic [IRQ_W-1:0] w1c;
	logic dph_valid_r;
	logic dph_write_r;
	logic [7:0] dph_addr_r;
	logic [1:0] warm_r;
	logic [FILL16_STEPS-1:0] thr;
	logic [3:0] fill16;
	logic stale_hit;
	logic static_cond;
	logic gen_malf;
	logic accept;
	logic wr_en;
	logic rd_ext;
	logic [31:0] rd_mux;

	csb_tick_div #(.DIV(TICK_DIV)) u_tick (
		.hclk(hclk),
		.hresetn(hresetn),
		.tick_o(tick)
	);

	// Fill in sixteenths: count thresholds that 16*count exceeds
	genvar gi;
	generate
		for (gi = 1; gi <= FILL16_STEPS; gi++)
		begin : g_thr
			assign thr[gi-1] = ({meas_r.buf_count, 4'h0} >
				(12'(gi) * {4'h0, avg_r}));
		end
	endgenerate

	always_comb
	begin
		fill16 = 4'h0;
		for (int i = 0; i < FILL16_STEPS; i++)
			fill16 = fill16 + 4'(thr[i]);
	end

	assign stale_hit = (stale_r >= STALE_LIMIT_S);
	// No measured values counts as a static fault too
	assign static_cond = meas_r.acoustic_virtual_temperature_fault | stale_hit;
	assign gen_malf = (avg_r < AVG_SPLIT_S) ? stale_hit
		: ({meas_r.buf_count, 1'b0} < {1'b0, avg_r});

	always_comb
	begin
		ext_nxt = 32'h0;
		ext_nxt[EX_GEN] = gen_malf;
		ext_nxt[EX_HCRIT] = meas_r.heat_criterion;
		ext_nxt[EX_HON] = meas_r.heat_on;
		ext_nxt[EX_STATIC] = (static_sec_r > STATIC_LIMIT_S);
		ext_nxt[EX_FILL_HI:EX_FILL_LO] = fill16;
		ext_nxt[EX_RESTART] = restart_r;
	end

	// Rising edges of general malfunction, static malfunction and heating on raise interrupts
	assign evt[IRQ_GEN] = ext_nxt[EX_GEN] & ~ext_r[EX_GEN];
	assign evt[IRQ_STATIC] = ext_nxt[EX_STATIC] & ~ext_r[EX_STATIC];
	assign evt[IRQ_HEAT] = ext_nxt[EX_HON] & ~ext_r[EX_HON];

	assign accept = hsel & hready & htrans[1];
	assign wr_en = dph_valid_r & dph_write_r;
	assign rd_ext = accept & ~hwrite & (haddr[7:0] == OFS_EXTENDED);
	assign w1c = (wr_en && dph_addr_r == OFS_IRQ_STAT) ?
		hwdata[IRQ_W-1:0] : {IRQ_W{1'b0}};
	// Set beats clear in the same cycle so no event is lost
	assign irq_stat_nxt = (irq_stat_r & ~w1c) | evt;

	assign rd_mux =
		(haddr[7:0] == OFS_AVG_TIME) ? {24'h0, avg_r} :
		(haddr[7:0] == OFS_COMPACT) ? {24'h0, compact_status_o} :
		(haddr[7:0] == OFS_EXTENDED) ? ext_r :
		(haddr[7:0] == OFS_IRQ_STAT) ? {29'h0, irq_stat_r} :
		(haddr[7:0] == OFS_IRQ_MASK) ? {29'h0, irq_mask_r} : 32'h0;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			dph_valid_r <= 1'b0;
			dph_write_r <= 1'b0;
			dph_addr_r <= 8'h0;
			hrdata <= 32'h0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
		else
		begin
			dph_valid_r <= accept;
			dph_write_r <= hwrite;
			dph_addr_r <= haddr[7:0];
			if (accept && !hwrite)
				hrdata <= rd_mux;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			avg_r <= AVG_TIME_RESET;
			irq_mask_r <= {IRQ_W{1'b0}};
			irq_stat_r <= {IRQ_W{1'b0}};
			irq_o <= 1'b0;
		end
		else
		begin
			if (wr_en && dph_addr_r == OFS_AVG_TIME)
				avg_r <= hwdata[7:0];
			if (wr_en && dph_addr_r == OFS_IRQ_MASK)
				irq_mask_r <= hwdata[IRQ_W-1:0];
			irq_stat_r <= irq_stat_nxt;
			irq_o <= |(irq_stat_r & irq_mask_r);
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			meas_r <= '0;
			stale_r <= 8'h0;
			static_sec_r <= 8'h0;
			restart_r <= 1'b1;
			warm_r <= 2'h0;
		end
		else
		begin
			meas_r <= meas_i;
			if (meas_r.new_value)
				stale_r <= 8'h0;
			else if (tick && stale_r != SAT_S)
				stale_r <= stale_r + 8'h1;
			if (!static_cond)
				static_sec_r <= 8'h0;
			else if (tick && static_sec_r != SAT_S)
				static_sec_r <= static_sec_r + 8'h1;
			// First read of the extended word after restart clears it
			if (rd_ext)
				restart_r <= 1'b0;
			if (warm_r != 2'h3)
				warm_r <= warm_r + 2'h1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ext_r <= 32'h0;
			compact_status_o <= 8'h0;
		end
		else
		begin
			ext_r <= ext_nxt;
			compact_status_o[CB_GEN] <= ext_r[EX_GEN];
			compact_status_o[CB_FILL_LO +: 3] <= ext_r[EX_FILL_HI -: 3];
			compact_status_o[CB_RSV] <= 1'b0;
			compact_status_o[CB_STATIC] <= ext_r[EX_STATIC];
			compact_status_o[CB_HCRIT] <= ext_r[EX_HCRIT];
			compact_status_o[CB_HON] <= ext_r[EX_HON];
		end
	end

	property p_gen_short;
		@(posedge hclk) disable iff (!hresetn)
		(avg_r < AVG_SPLIT_S && stale_r >= STALE_LIMIT_S) |->
			##2 compact_status_o[CB_GEN];
	endproperty
	a_gen_short: assert property (p_gen_short)
		else $error("general malfunction missing after stale period");

	property p_gen_long;
		@(posedge hclk) disable iff (!hresetn)
		(avg_r >= AVG_SPLIT_S && {meas_r.buf_count, 1'b0} >= {1'b0, avg_r})
			|-> ##2 !compact_status_o[CB_GEN];
	endproperty
	a_gen_long: assert property (p_gen_long)
		else $error("general malfunction set with buffer half full");

	property p_fill_full;
		@(posedge hclk) disable iff (!hresetn)
		(avg_r != 8'h0 && meas_r.buf_count >= avg_r) |->
			##2 (compact_status_o[CB_FILL_LO +: 3] == 3'h7);
	endproperty
	a_fill_full: assert property (p_fill_full)
		else $error("full buffer not reported as code 7");

	property p_static_clear;
		@(posedge hclk) disable iff (!hresetn)
		!static_cond |-> ##3 !compact_status_o[CB_STATIC];
	endproperty
	a_static_clear: assert property (p_static_clear)
		else $error("static malfunction set without lasting fault");

	property p_static_set;
		@(posedge hclk) disable iff (!hresetn)
		(static_sec_r > STATIC_LIMIT_S) |-> ##2 compact_status_o[CB_STATIC];
	endproperty
	a_static_set: assert property (p_static_set)
		else $error("static malfunction missing after one minute");

	property p_heat_crit;
		@(posedge hclk) disable iff (!hresetn)
		(warm_r == 2'h3) |->
			compact_status_o[CB_HCRIT] == $past(meas_i.heat_criterion, 3);
	endproperty
	a_heat_crit: assert property (p_heat_crit)
		else $error("heating criterion bit does not follow input");

	property p_heat_on;
		@(posedge hclk) disable iff (!hresetn)
		(warm_r == 2'h3) |->
			compact_status_o[CB_HON] == $past(meas_i.heat_on, 3);
	endproperty
	a_heat_on: assert property (p_heat_on)
		else $error("heating on bit does not follow input");

	property p_derived;
		@(posedge hclk) disable iff (!hresetn)
		##1 (compact_status_o[CB_GEN] == $past(ext_r[EX_GEN]) &&
			compact_status_o[CB_FILL_LO +: 3] ==
			$past(ext_r[EX_FILL_HI -: 3]));
	endproperty
	a_derived: assert property (p_derived)
		else $error("compact byte disagrees with extended word");

	property p_reserved;
		@(posedge hclk) disable iff (!hresetn)
		!compact_status_o[CB_RSV];
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("reserved bit 4 not zero");

	c_gen: cover property (@(posedge hclk) $rose(compact_status_o[CB_GEN]));
	c_static: cover property
		(@(posedge hclk) $rose(compact_status_o[CB_STATIC]));
	c_irq: cover property (@(posedge hclk) $rose(irq_o));
endmodule : csb_status_top

// [sim/csb_host_model.sv]
// AHB-Lite master standing in for the host that reads the status
`timescale 1ns/1ps
module csb_host_model (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic req,
	input wire logic wr,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	output logic done,
	output logic [31:0] rdata,
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata
);
	logic [1:0] st_r;
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			st_r <= 2'h0;
			done <= 1'b0;
			rdata <= 32'h0;
			hsel <= 1'b0;
			haddr <= 32'h0;
			htrans <= 2'h0;
			hwrite <= 1'b0;
			hsize <= 3'h2;
			hwdata <= 32'h0;
		end
		else if (st_r == 2'h0)
		begin
			done <= 1'b0;
			if (req && !done)
			begin
				hsel <= 1'b1;
				htrans <= 2'h2;
				haddr <= {24'h0, addr};
				hwrite <= wr;
				st_r <= 2'h1;
			end
		end
		else if (st_r == 2'h1 && hready)
		begin
			htrans <= 2'h0;
			hwdata <= wdata;
			st_r <= 2'h2;
		end
		else if (st_r == 2'h2 && hready)
		begin
			rdata <= hrdata;
			done <= 1'b1;
			// Released data lines must not keep the last value
			hwdata <= ~hwdata;
			st_r <= 2'h0;
		end
	end
endmodule : csb_host_model

// [sim/compact_status_byte_encoder_tb_top.sv]
// Self-checking bench for the compact status byte encoder
`timescale 1ns/1ps
module compact_status_byte_encoder_tb_top;
	import csb_pkg::*;
	localparam int unsigned TD = 20;
	logic hclk = 0, hresetn = 0, req = 0, wr = 0, nv_en = 0, nv = 0;
	logic vt = 0, hc = 0, ho = 0, done, hsel, hwrite, hreadyout, hresp, irq;
	logic [7:0] addr = 0, cnt = 0, avg, cs;
	logic [31:0] wdata = 0, rdata, haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	csb_meas_type meas;
	int err_count = 0, n_tests = 0, i;
	assign meas = '{new_value: nv, acoustic_virtual_temperature_fault: vt,
		heat_criterion: hc, heat_on: ho, buf_count: cnt};
	csb_status_top #(.TICK_DIV(TD)) dut (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.meas_i(meas), .compact_status_o(cs), .irq_o(irq));
	csb_host_model host (.hclk(hclk), .hresetn(hresetn), .req(req), .wr(wr),
		.addr(addr), .wdata(wdata), .done(done), .rdata(rdata), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));
	initial
	begin
		forever #50 hclk = ~hclk;
	end
	// Measured values arrive at random while enabled
	always @(posedge hclk) nv <= nv_en && ($urandom_range(3) == 0);
	task test_done;
		$display("errors %0d checks %0d", err_count, n_tests);
		if (err_count == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : test_done
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
			err_count++;
		end
	endtask : chk
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge hclk);
		req <= 1'b1;
		wr <= w;
		addr <= a;
		wdata <= d;
		for (k = 0; k < 50 && done !== 1'b1; k++) @(negedge hclk);
		if (done !== 1'b1)
		begin
			err_count++;
			test_done;
		end
		@(posedge hclk);
		req <= 1'b0;
	endtask : bus
	task settle(input int n);
		repeat (n) @(negedge hclk);
	endtask : settle
	// Fill code: ceil(8*c/a)-1, empty gives 0, full or more gives 7
	function automatic logic [2:0] fexp(logic [7:0] c, logic [7:0] a);
		int k;
		if (c == 0)
			return 3'h0;
		if (c >= a)
			return 3'h7;
		k = (8 * c + a - 1) / a - 1;
		return k[2:0];
	endfunction : fexp
	initial
	begin
		void'($urandom(32'h8D97));
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		nv_en <= 1'b1;
		settle(1);
		chk("compact", cs, 32'h0);
		chk("hresp", hresp, 1'b0);
		chk("hready", hreadyout, 1'b1);
		bus(0, OFS_AVG_TIME, 0);
		chk("avg_time", rdata, 32'h0A);
		bus(0, 8'h40, 0);
		chk("unmapped", rdata, 32'h0);
		bus(0, OFS_EXTENDED, 0);
		chk("restart", rdata[13], 1'b1);
		bus(0, OFS_EXTENDED, 0);
		chk("restart", rdata[13], 1'b0);
		for (i = 0; i < 16; i++)
		begin
			avg = (i < 4) ? 8'h0A : 8'($urandom_range(40, 10));
			@(posedge hclk);
			cnt <= (i == 0) ? 8'h05 : (i == 1) ? 8'h04 : (i == 2) ? 8'h00 :
				(i == 3) ? avg : 8'($urandom_range(avg));
			hc <= 1'($urandom);
			ho <= 1'($urandom);
			bus(1, OFS_AVG_TIME, {24'h0, avg});
			settle(6);
			chk("gen", cs[0], 2 * cnt < avg);
			chk("fill", cs[3:1], fexp(cnt, avg));
			chk("rsv", cs[4], 1'b0);
			chk("hcrit", cs[6], hc);
			chk("hon", cs[7], ho);
			bus(0, OFS_EXTENDED, 0);
			chk("ext", {rdata[11:9], rdata[4], rdata[2:0]},
				{fexp(cnt, avg), 1'b0, ho, hc, 2 * cnt < avg});
			bus(0, OFS_COMPACT, 0);
			chk("compact_rd", rdata,
				{24'h0, ho, hc, 2'h0, fexp(cnt, avg), 2 * cnt < avg});
		end
		bus(1, OFS_AVG_TIME, 32'h05);
		@(posedge hclk);
		nv_en <= 1'b0;
		// Margin for a last measured value a few cycles before the stop
		settle(7 * TD);
		chk("stale", cs[0], 1'b0);
		settle(5 * TD);
		chk("stale", cs[0], 1'b1);
		@(posedge hclk);
		nv_en <= 1'b1;
		settle(40);
		chk("fresh", cs[0], 1'b0);
		@(posedge hclk);
		vt <= 1'b1;
		settle(55 * TD);
		chk("static", cs[5], 1'b0);
		chk("irq", irq, 1'b0);
		settle(10 * TD);
		chk("static", cs[5], 1'b1);
		chk("irq", irq, 1'b0);
		bus(1, OFS_IRQ_MASK, 32'h2);
		settle(3);
		chk("irq", irq, 1'b1);
		bus(0, OFS_IRQ_STAT, 0);
		chk("irq_stat", rdata[1], 1'b1);
		bus(1, OFS_IRQ_STAT, 32'h2);
		settle(3);
		chk("irq", irq, 1'b0);
		@(posedge hclk);
		vt <= 1'b0;
		settle(5);
		chk("static", cs[5], 1'b0);
		test_done;
	end
endmodule : compact_status_byte_encoder_tb_top
